// ---- verilog/lre_params.svh ----
// named constants for the ladder relay and edge logic evaluator
`ifndef LRE_PARAMS_SVH
`define LRE_PARAMS_SVH

// edge history capacity, larger and smaller controller variants
`define LRE_EDGE_DEPTH 2048
`define LRE_EDGE_DEPTH_SMALL 512

// bit levels
`define LRE_OFF 1'b0
`define LRE_ON 1'b1

// device address width and reset value of the device write address
`define LRE_DEV_W 16
`define LRE_DEV_RST 16'h0000

`endif

// ---- verilog/lre_pkg.sv ----
// types shared by the ladder relay and edge logic evaluator
package lre_pkg;

  // ladder element to evaluate
  typedef enum logic [3:0] {
    LRE_OP_NO,
    LRE_OP_NC,
    LRE_OP_RISE,
    LRE_OP_FALL,
    LRE_OP_COIL,
    LRE_OP_FCOIL,
    LRE_OP_INV,
    LRE_OP_ICOIL,
    LRE_OP_PPULSE,
    LRE_OP_NPULSE
  } lre_op_t;

endpackage : lre_pkg

// ---- verilog/lre_hist.sv ----
// per-instance previous-scan history bits for edge elements
`timescale 1ns/1ps
`include "lre_params.svh"

module lre_hist #(
  parameter int DEPTH = `LRE_EDGE_DEPTH,
  parameter int IDX_W = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bulk clear at start of run
  input wire logic clear,
  // write port
  input wire logic we,
  input wire logic [IDX_W-1:0] waddr,
  input wire logic wdata,
  // read port, combinational
  input wire logic [IDX_W-1:0] raddr,
  output logic rdata
);
  import lre_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] bits;
  } lre_hist_state_t;

  lre_hist_state_t st;
  lre_hist_state_t next_st;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_st = st;
    // a flat vector lets the whole history clear in one cycle
    if (clear)
    begin
      next_st.bits = '0;
    end
    else if (we)
    begin
      next_st.bits[waddr] = wdata;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.bits[raddr];

endmodule : lre_hist

// ---- verilog/lre_eval.sv ----
// ladder relay element evaluator with per-instance edge history
// How it works
// - nc contact output on only when input on and device off.
// - rising transitional contact on one scan when input goes off to on.
// - falling transitional contact on one scan when input goes on to off.
// - coil writes device equal to its input on each evaluation.
// - forced coil writes nothing; device keeps its value.
// - forced device is changed only by the programming tool port.
// - inverter output is the complement of its input.
// - invert coil writes the complement of its input to the device.
// - positive pulse on when input on and device went off to on.
// - no contact output on only when input on and device on.
// - negative pulse on when input on and device went on to off.
`timescale 1ns/1ps
`include "lre_params.svh"

module lre_eval #(
  parameter int EDGE_DEPTH = `LRE_EDGE_DEPTH,
  parameter int IDX_W = $clog2(EDGE_DEPTH),
  parameter int DEV_W = `LRE_DEV_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // start of run
  input wire logic run_start,
  // element evaluation request
  input wire logic eval,
  output logic eval_ready,
  input wire lre_pkg::lre_op_t op,
  input wire logic [IDX_W-1:0] edge_idx,
  input wire logic power_in,
  input wire logic dev_in,
  input wire logic [DEV_W-1:0] dev_addr,
  // programming tool write
  input wire logic tool_we,
  input wire logic [DEV_W-1:0] tool_addr,
  input wire logic tool_wdata,
  // power flow result
  output logic out_valid,
  output logic power_out,
  // device bit write
  output logic dev_we,
  output logic [DEV_W-1:0] dev_waddr,
  output logic dev_wdata,
  output logic dev_by_tool
);
  import lre_pkg::*;

  typedef struct packed {
    logic out_valid;
    logic power_out;
    logic dev_we;
    logic [DEV_W-1:0] dev_waddr;
    logic dev_wdata;
    logic dev_by_tool;
  } lre_state_t;

  lre_state_t st;
  lre_state_t next_st;
  logic taken;
  logic hist_rd;
  logic hist_we;
  logic hist_wd;

  // ************************************************************
  // edge history
  // ************************************************************
  // depth covers the larger variant; the program keeps within it
  lre_hist #(
    .DEPTH(EDGE_DEPTH),
    .IDX_W(IDX_W)
  ) lre_hist_inst (
    .clock(clock),
    .rstn(rstn),
    .clear(run_start),
    .we(hist_we),
    .waddr(edge_idx),
    .wdata(hist_wd),
    .raddr(edge_idx),
    .rdata(hist_rd)
  );

  // a tool write or a run start owns the cycle; the element waits
  assign eval_ready = !tool_we && !run_start;
  assign taken = eval && eval_ready;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_st = st;
    next_st.out_valid = `LRE_OFF;
    next_st.power_out = `LRE_OFF;
    next_st.dev_we = `LRE_OFF;
    next_st.dev_by_tool = `LRE_OFF;
    hist_we = `LRE_OFF;
    hist_wd = `LRE_OFF;
    if (tool_we)
    begin
      next_st.dev_we = `LRE_ON;
      next_st.dev_waddr = tool_addr;
      next_st.dev_wdata = tool_wdata;
      next_st.dev_by_tool = `LRE_ON;
    end
    else if (taken)
    begin
      next_st.dev_waddr = dev_addr;
      unique case (op)
        LRE_OP_NO:
        begin
          next_st.out_valid = `LRE_ON;
          next_st.power_out = power_in && dev_in;
        end
        LRE_OP_NC:
        begin
          next_st.out_valid = `LRE_ON;
          next_st.power_out = power_in && !dev_in;
        end
        LRE_OP_RISE:
        begin
          next_st.out_valid = `LRE_ON;
          next_st.power_out = power_in && !hist_rd;
          hist_we = `LRE_ON;
          hist_wd = power_in;
        end
        LRE_OP_FALL:
        begin
          next_st.out_valid = `LRE_ON;
          next_st.power_out = !power_in && hist_rd;
          hist_we = `LRE_ON;
          hist_wd = power_in;
        end
        LRE_OP_COIL:
        begin
          next_st.dev_we = `LRE_ON;
          next_st.dev_wdata = power_in;
        end
        LRE_OP_FCOIL:
        begin
          // no write at all, the device keeps whatever it held
          next_st.dev_we = `LRE_OFF;
        end
        LRE_OP_INV:
        begin
          next_st.out_valid = `LRE_ON;
          next_st.power_out = !power_in;
        end
        LRE_OP_ICOIL:
        begin
          next_st.dev_we = `LRE_ON;
          next_st.dev_wdata = !power_in;
        end
        LRE_OP_PPULSE:
        begin
          // history tracks the device, not the input
          next_st.out_valid = `LRE_ON;
          next_st.power_out = power_in && dev_in && !hist_rd;
          hist_we = `LRE_ON;
          hist_wd = dev_in;
        end
        LRE_OP_NPULSE:
        begin
          next_st.out_valid = `LRE_ON;
          next_st.power_out = power_in && !dev_in && hist_rd;
          hist_we = `LRE_ON;
          hist_wd = dev_in;
        end
        default:
        begin
          // illegal opcode: nothing is produced
          next_st.out_valid = `LRE_OFF;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st.out_valid <= `LRE_OFF;
      st.power_out <= `LRE_OFF;
      st.dev_we <= `LRE_OFF;
      st.dev_waddr <= DEV_W'(`LRE_DEV_RST);
      st.dev_wdata <= `LRE_OFF;
      st.dev_by_tool <= `LRE_OFF;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign out_valid = st.out_valid;
  assign power_out = st.power_out;
  assign dev_we = st.dev_we;
  assign dev_waddr = st.dev_waddr;
  assign dev_wdata = st.dev_wdata;
  assign dev_by_tool = st.dev_by_tool;

  // ************************************************************
  // checks
  // ************************************************************
  a_nc_contact: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_NC |=> out_valid && power_out == ($past(power_in) && !$past(dev_in)))
    else $error("nc contact output wrong");

  a_no_contact: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_NO |=> out_valid && power_out == ($past(power_in) && $past(dev_in)))
    else $error("no contact output wrong");

  a_rise_edge: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_RISE |=> power_out == ($past(power_in) && !$past(hist_rd)))
    else $error("rising contact output wrong");

  a_fall_edge: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_FALL |=> power_out == (!$past(power_in) && $past(hist_rd)))
    else $error("falling contact output wrong");

  a_coil_write: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_COIL |=> dev_we && !out_valid && dev_wdata == $past(power_in)
      && dev_waddr == $past(dev_addr))
    else $error("coil write wrong");

  a_fcoil_hold: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_FCOIL |=> !dev_we && !out_valid)
    else $error("forced coil wrote a device");

  a_tool_write: assert property (@(posedge clock) disable iff (!rstn)
    tool_we |-> !eval_ready ##1 dev_we && dev_by_tool && dev_wdata == $past(tool_wdata))
    else $error("tool write not served");

  a_inverter_out: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_INV |=> out_valid && power_out != $past(power_in))
    else $error("inverter output wrong");

  a_icoil_write: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_ICOIL |=> dev_we && dev_wdata != $past(power_in))
    else $error("invert coil write wrong");

  a_ppulse_out: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_PPULSE
      |=> power_out == ($past(power_in) && $past(dev_in) && !$past(hist_rd)))
    else $error("positive pulse output wrong");

  a_npulse_out: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_NPULSE
      |=> power_out == ($past(power_in) && !$past(dev_in) && $past(hist_rd)))
    else $error("negative pulse output wrong");

  a_hist_clear: assert property (@(posedge clock) disable iff (!rstn)
    run_start |=> !hist_rd)
    else $error("history not cleared at run start");

  a_hist_repeat: assert property (@(posedge clock) disable iff (!rstn)
    taken && op == LRE_OP_RISE && power_in ##1 taken && op == LRE_OP_RISE
      && edge_idx == $past(edge_idx) |=> !power_out)
    else $error("rising contact fired twice");

  a_idle_quiet: assert property (@(posedge clock) disable iff (!rstn)
    !taken && !tool_we |=> !dev_we && !out_valid)
    else $error("output without a request");

endmodule : lre_eval

// ---- sim/lre_eval_test.sv ----
// self-checking bench for the ladder relay and edge logic evaluator
`timescale 1ns/1ps
`include "lre_params.svh"

`define LRE_CHECK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected %s: expected %h seen %h", what, exp, got); \
    end \
  end

module lre_eval_test;
  import lre_pkg::*;
  localparam int DEPTH = 16;
  localparam int IW = 4;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic run_start = 1'b0;
  logic eval = 1'b0;
  lre_op_t op = LRE_OP_NO;
  logic [IW-1:0] edge_idx = 4'h0;
  logic power_in = 1'b0;
  logic dev_in = 1'b0;
  logic [15:0] dev_addr = 16'h0000;
  logic tool_we = 1'b0;
  logic [15:0] tool_addr = 16'h0000;
  logic tool_wdata = 1'b0;
  logic eval_ready, out_valid, power_out, dev_we, dev_wdata, dev_by_tool;
  logic [15:0] dev_waddr;
  int err_count = 0;
  int compares = 0;
  int seed = 32'h7d9248e3;
  logic [19:0] exp_q[$];
  logic hist[DEPTH];

  always #2.5 clock = ~clock;

  lre_eval #(.EDGE_DEPTH(DEPTH)) lre_eval_inst (
    .clock(clock), .rstn(rstn), .run_start(run_start), .eval(eval),
    .eval_ready(eval_ready), .op(op), .edge_idx(edge_idx), .power_in(power_in),
    .dev_in(dev_in), .dev_addr(dev_addr), .tool_we(tool_we), .tool_addr(tool_addr),
    .tool_wdata(tool_wdata), .out_valid(out_valid), .power_out(power_out),
    .dev_we(dev_we), .dev_waddr(dev_waddr), .dev_wdata(dev_wdata),
    .dev_by_tool(dev_by_tool)
  );

  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(posedge clock)
  begin
    logic [19:0] e;
    #1;
    if (rstn === 1'b1 && (out_valid !== 1'b0 || dev_we !== 1'b0))
    begin
      if (exp_q.size() == 0)
      begin
        `LRE_CHECK("spare result", 1'b0, 1'b1)
      end
      else
      begin
        e = exp_q.pop_front();
        `LRE_CHECK("result", e, {out_valid, dev_we, dev_by_tool, dev_we ? dev_wdata : power_out,
          dev_we ? dev_waddr : 16'h0000})
      end
    end
  end

  function automatic logic [19:0] out_e(input logic v);
    return {2'b10, 1'b0, v, 16'h0000};
  endfunction : out_e

  function automatic logic [19:0] wr_e(input logic v);
    return {2'b01, 1'b0, v, dev_addr};
  endfunction : wr_e

  // ****************************************************************
  // stimulus and reference
  // ****************************************************************
  // each edge kind gets its own index group so sharing rules do not matter
  task automatic step(input logic side);
    logic [31:0] r;
    logic [31:0] r2;
    logic [IW-1:0] i;
    @(negedge clock);
    r = $random(seed);
    r2 = $random(seed);
    op = lre_op_t'(r[3:0]);
    power_in = r[4];
    dev_in = r[5];
    eval = r[6] | r[7];
    tool_we = side && (r[10:8] == 3'h0);
    run_start = side && (r[14:11] == 4'h0);
    i = {r[3:0] >= LRE_OP_PPULSE, r[3:0] == LRE_OP_FALL || r[3:0] == LRE_OP_NPULSE, r[17:16]};
    // the program keeps every index inside the history depth
    edge_idx = (r[3:0] inside {2, 3, 8, 9}) ? i : r[27:24];
    dev_addr = r2[15:0];
    tool_addr = r2[31:16];
    tool_wdata = r[20];
    i = edge_idx;
    #1;
    `LRE_CHECK("eval_ready", !(tool_we | run_start), eval_ready)
    if (tool_we)
      exp_q.push_back({3'b011, tool_wdata, tool_addr});
    if (eval && !tool_we && !run_start)
    begin
      case (op)
        LRE_OP_NO: exp_q.push_back(out_e(power_in & dev_in));
        LRE_OP_NC: exp_q.push_back(out_e(power_in & !dev_in));
        LRE_OP_RISE: exp_q.push_back(out_e(power_in & !hist[i]));
        LRE_OP_FALL: exp_q.push_back(out_e(!power_in & hist[i]));
        LRE_OP_COIL: exp_q.push_back(wr_e(power_in));
        LRE_OP_INV: exp_q.push_back(out_e(!power_in));
        LRE_OP_ICOIL: exp_q.push_back(wr_e(!power_in));
        LRE_OP_PPULSE: exp_q.push_back(out_e(power_in & dev_in & !hist[i]));
        LRE_OP_NPULSE: exp_q.push_back(out_e(power_in & !dev_in & hist[i]));
        default: ;
      endcase
      if (op == LRE_OP_RISE || op == LRE_OP_FALL)
        hist[i] = power_in;
      if (op == LRE_OP_PPULSE || op == LRE_OP_NPULSE)
        hist[i] = dev_in;
    end
    if (run_start)
      foreach (hist[k]) hist[k] = 1'b0;
  endtask : step

  // directed walk: run start, then one rising contact taken twice with input on
  task automatic rise_twice();
    @(negedge clock);
    eval = 1'b0;
    tool_we = 1'b0;
    run_start = 1'b1;
    foreach (hist[k]) hist[k] = 1'b0;
    @(negedge clock);
    run_start = 1'b0;
    eval = 1'b1;
    op = LRE_OP_RISE;
    edge_idx = 4'h5;
    power_in = 1'b1;
    exp_q.push_back(out_e(1'b1));
    @(negedge clock);
    exp_q.push_back(out_e(1'b0));
    hist[5] = 1'b1;
    @(negedge clock);
    eval = 1'b0;
  endtask : rise_twice

  task automatic do_reset();
    @(negedge clock);
    rstn = 1'b0;
    eval = 1'b0;
    tool_we = 1'b0;
    run_start = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    `LRE_CHECK("outputs in reset", 20'h0, {out_valid, dev_we, dev_by_tool, dev_waddr})
    exp_q.delete();
    foreach (hist[k]) hist[k] = 1'b0;
    @(negedge clock);
    rstn = 1'b1;
  endtask : do_reset

  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    int n;
    do_reset();
    repeat (600) step(1'b0);
    $display("test plain_evaluation done");
    repeat (600) step(1'b1);
    $display("test tool_and_restart_mix done");
    rise_twice();
    $display("test rise_twice done");
    do_reset();
    repeat (400) step(1'b1);
    $display("test after_second_reset done");
    @(negedge clock);
    eval = 1'b0;
    tool_we = 1'b0;
    run_start = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    `LRE_CHECK("results left over", 0, exp_q.size())
    give_verdict();
  end
endmodule : lre_eval_test
